// ===== rtl/vcs_pkg.sv
// Package: constants for the vertical countdown sync block
package vcs_pkg;
	// Oscillator rate in Hz, kept whole so the half kilohertz is not lost
	localparam int OSC_FREQ_HZ = 503500;
	// Last prescaler count, a double line tick every sixteen oscillator periods
	localparam logic [3:0] PRESCALE_LAST = 4'hF;
	// Width of the vertical counter, room well beyond 574
	localparam int VCNT_W = 10;
	// Count at which the sync window opens
	localparam logic [VCNT_W-1:0] WIN_OPEN = 10'h1FE;
	// Count at which the sync window closes
	localparam logic [VCNT_W-1:0] WIN_CLOSE = 10'h23E;
	// Count at which the counter resets itself when no sync came
	localparam logic [VCNT_W-1:0] DEFAULT_CNT = 10'h21E;
	// Reset values
	localparam logic [VCNT_W-1:0] VCNT_RST = 10'h000;
	localparam logic [3:0] PRESCALE_RST = 4'h0;
	// Prescaler states for the tick sequencer
	typedef enum logic [1:0] {
		VCS_IDLE = 2'b00,
		VCS_RUN = 2'b01
	} vcs_state_t;
endpackage : vcs_pkg

// ===== rtl/vcs_top.sv
// Module: counter-based horizontal and vertical timing with sync window
// Behaviour
// - Divide oscillator by sixteen into double line tick
// - Halve double tick, drive horizontal square wave
// - Tick-clocked flip-flop resets the vertical counter
// - Ignore vertical sync before count 510
// - Accepted sync sets reset flip-flop on next tick, counter zeroed on the tick after
// - Self reset at count 542 without sync
// - Sync window spans counts 510 to 573, only up to 543 reached
// - Each counter reset starts the retrace interval
// - Retrace ends when threshold input is reached
// - Burst gate low first half, released at peak
module vcs_top
	import vcs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Pins from the outside world, asynchronous
	input wire logic osc_in,
	input wire logic vsync_in,
	input wire logic retrace_done_in,
	input wire logic flyback_in,
	input wire logic flyback_peak_in,
	// Timing outputs
	output logic h_drive_r,
	output logic double_line_tick,
	output logic vert_reset_r,
	output logic retrace_active_r,
	output logic burst_gate_r,
	output logic [VCNT_W-1:0] vcount_r
);

	// Two-flop synchronisers, first stage read only by second
	logic [4:0] pin_meta_r;
	logic [4:0] pin_sync_r;
	logic osc_d_r; // Previous synced oscillator level
	logic osc_rise; // One-cycle pulse per oscillator period
	logic vsync_d_r; // Previous synced vertical sync
	logic vsync_rise; // Leading edge of vertical sync
	logic [3:0] sixteen_prescaler_r; // Oscillator period count
	logic sync_seen_r; // Sync edge caught inside the window
	logic sync_window_gate; // Window open for sync
	logic sync_input_gate; // Sync allowed through the window
	logic default_reset_gate; // Counter ran out without sync
	logic reset_to_retrace_gate; // One-cycle reset pulse to retrace
	logic flyback_s;
	logic peak_s;
	logic retrace_done_s;
	logic vsync_s;
	logic osc_s;
	logic peak_seen_r; // Flyback peak already passed

	assign osc_s = pin_sync_r[0];
	assign vsync_s = pin_sync_r[1];
	assign retrace_done_s = pin_sync_r[2];
	assign flyback_s = pin_sync_r[3];
	assign peak_s = pin_sync_r[4];

	// Synchronise every pin before any logic looks at it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta_r <= 5'h00;
			pin_sync_r <= 5'h00;
		end else begin
			pin_meta_r <= {flyback_peak_in, flyback_in, retrace_done_in, vsync_in, osc_in};
			pin_sync_r <= pin_meta_r;
		end
	end

	// Edge history of the synced oscillator and sync levels
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_d_r <= 1'b0;
			vsync_d_r <= 1'b0;
		end else begin
			osc_d_r <= osc_s;
			vsync_d_r <= vsync_s;
		end
	end

	assign osc_rise = osc_s & ~osc_d_r;
	assign vsync_rise = vsync_s & ~vsync_d_r;

	// Divide oscillator periods by sixteen
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sixteen_prescaler_r <= PRESCALE_RST;
		end else if (osc_rise) begin
			sixteen_prescaler_r <= sixteen_prescaler_r + 4'h1;
		end
	end

	// Tick is a single-cycle enable, everything slower runs off it
	assign double_line_tick = osc_rise && (sixteen_prescaler_r == PRESCALE_LAST);

	// Line divider stage: horizontal drive toggles on every tick
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			h_drive_r <= 1'b0;
		end else if (double_line_tick) begin
			h_drive_r <= ~h_drive_r;
		end
	end

	// Window decode; beyond one past the default count it can never be reached
	assign sync_window_gate = (vcount_r >= WIN_OPEN) && (vcount_r < WIN_CLOSE);
	assign sync_input_gate = sync_window_gate && (sync_seen_r || vsync_rise);
	// The lower default wins, so the counter never climbs to the window's top
	assign default_reset_gate = (vcount_r >= DEFAULT_CNT);

	// Catch a sync edge only while the window is open; a new edge wins
	// over the clear at the tick so a sync landing on the tick is kept
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync_seen_r <= 1'b0;
		end else if (vsync_rise && sync_window_gate) begin
			sync_seen_r <= 1'b1;
		end else if (double_line_tick) begin
			sync_seen_r <= 1'b0;
		end
	end

	// Reset flip-flop: data from the gated sync or the default gate, clocked by the tick
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			vert_reset_r <= 1'b0;
		end else if (double_line_tick) begin
			// Held off while a request stands, so each request lasts one tick period;
			// the default gate is still true at the top count and would reset twice
			vert_reset_r <= !vert_reset_r && (sync_input_gate || default_reset_gate);
		end
	end

	// Vertical count stages: zero on the tick after a reset request
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			vcount_r <= VCNT_RST;
		end else if (double_line_tick) begin
			if (vert_reset_r) begin
				vcount_r <= VCNT_RST;
			end else begin
				vcount_r <= vcount_r + 10'h001;
			end
		end
	end

	// One-cycle reset pulse forwarded to retrace timing
	assign reset_to_retrace_gate = double_line_tick && vert_reset_r;

	// Retrace latch: set by reset, cleared by the threshold; set wins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			retrace_active_r <= 1'b0;
		end else if (reset_to_retrace_gate) begin
			retrace_active_r <= 1'b1;
		end else if (retrace_done_s) begin
			retrace_active_r <= 1'b0;
		end
	end

	// Remember the flyback peak until the flyback ends
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			peak_seen_r <= 1'b0;
		end else if (!flyback_s) begin
			peak_seen_r <= 1'b0;
		end else if (peak_s) begin
			peak_seen_r <= 1'b1;
		end
	end

	// Burst gate: clamped low until the peak, then follows the flyback
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			burst_gate_r <= 1'b0;
		end else begin
			burst_gate_r <= flyback_s && (peak_seen_r || peak_s);
		end
	end

	// Helper: oscillator periods since the last tick, for checking only
	logic [4:0] osc_since_tick_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_since_tick_r <= 5'h00;
		end else if (double_line_tick) begin
			osc_since_tick_r <= 5'h00;
		end else if (osc_rise) begin
			osc_since_tick_r <= osc_since_tick_r + 5'h01;
		end
	end

	// Helper: set once the first tick has passed
	logic ticked_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ticked_r <= 1'b0;
		end else if (double_line_tick) begin
			ticked_r <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// Reusable steps of the vertical sequence
	sequence s_tick_request;
		double_line_tick && vert_reset_r;
	endsequence
	sequence s_tick_count;
		double_line_tick && !vert_reset_r;
	endsequence
	sequence s_early_tick;
		double_line_tick && (vcount_r < WIN_OPEN) && !vert_reset_r;
	endsequence

	a_prescale_sixteen: assert property (
		(double_line_tick && ticked_r) |-> (osc_since_tick_r == 5'h0F))
		else $error("tick not after sixteen oscillator periods");

	a_hdrive_toggle: assert property (
		double_line_tick |=> (h_drive_r != $past(h_drive_r)))
		else $error("horizontal drive did not toggle on tick");

	a_hdrive_steady: assert property (
		!double_line_tick |=> $stable(h_drive_r))
		else $error("horizontal drive moved without tick");

	a_count_zero: assert property (
		s_tick_request |=> (vcount_r == VCNT_RST))
		else $error("counter not zero after reset tick");

	a_count_step: assert property (
		s_tick_count |=> (vcount_r == $past(vcount_r) + 10'h001))
		else $error("counter did not advance by one");

	a_ignore_early: assert property (
		s_early_tick |=> !vert_reset_r)
		else $error("reset requested before window opened");

	a_accept_sync: assert property (
		(double_line_tick && !vert_reset_r && sync_window_gate && sync_seen_r) |=> vert_reset_r)
		else $error("sync inside window not accepted");

	a_default_reset: assert property (
		(double_line_tick && !vert_reset_r && vcount_r == DEFAULT_CNT) |=> vert_reset_r ##1
		(!double_line_tick)[*1])
		else $error("no default reset at count limit");

	a_count_bound: assert property (
		vcount_r <= DEFAULT_CNT + 10'h001)
		else $error("counter ran past the default limit");

	a_retrace_start: assert property (
		s_tick_request |=> retrace_active_r)
		else $error("retrace not started by reset");

	a_retrace_end: assert property (
		(retrace_active_r && retrace_done_s && !reset_to_retrace_gate) |=> !retrace_active_r)
		else $error("retrace did not end at threshold");

	a_burst_clamp: assert property (
		(!flyback_s || !(peak_s || peak_seen_r)) |=> !burst_gate_r)
		else $error("burst gate released before flyback peak");

	// Further guards: pulse widths, holding between ticks, window latch and burst gate release
	// A stuck tick or a doubled reset would slip past the checks above
	a_tick_single: assert property (
		double_line_tick |=> !double_line_tick)
		else $error("tick lasted more than one cycle");

	a_reset_single: assert property (
		s_tick_request |=> !vert_reset_r)
		else $error("reset request stood beyond one tick period");

	a_reset_only_tick: assert property (
		!double_line_tick |=> $stable(vert_reset_r))
		else $error("reset flip-flop changed without tick");

	a_count_hold: assert property (
		!double_line_tick |=> $stable(vcount_r))
		else $error("counter moved without tick");

	a_early_no_latch: assert property (
		(vsync_rise && !sync_window_gate && !sync_seen_r && !double_line_tick) |=> !sync_seen_r)
		else $error("sync caught outside the window");

	a_retrace_hold: assert property (
		(retrace_active_r && !retrace_done_s) |=> retrace_active_r)
		else $error("retrace ended before threshold");

	a_retrace_idle: assert property (
		(!retrace_active_r && !reset_to_retrace_gate) |=> !retrace_active_r)
		else $error("retrace started without reset pulse");

	a_burst_release: assert property (
		(flyback_s && peak_s) |=> burst_gate_r)
		else $error("burst gate not released at flyback peak");

endmodule : vcs_top

// ===== test/vcs_far_side.sv
// Far side model: oscillator source and retrace timing capacitor
module vcs_far_side #(
	// Cycles the capacitor takes to reach its threshold
	parameter int DONE_CYC = 20
) (
	// Clock
	input wire logic clk_sys,
	// From the block
	input wire logic retrace_active_r,
	// To the block
	output logic osc_in,
	output logic retrace_done_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// Fastest legal oscillator, two clocks high and low, keeps frames short
	initial begin
		osc_in = 1'b0;
		forever #20 osc_in = ~osc_in;
	end
	// Capacitor charges during retrace, threshold held until retrace ends
	initial begin
		retrace_done_in = 1'b0;
		forever begin
			@(posedge clk_sys);
			if (retrace_active_r === 1'b1) begin
				repeat (DONE_CYC) @(posedge clk_sys);
				#1 retrace_done_in = 1'b1;
				while (retrace_active_r !== 1'b0) @(posedge clk_sys);
				#1 retrace_done_in = 1'b0;
			end
		end
	end
endmodule : vcs_far_side

// ===== test/vertical_countdown_sync_bench.sv
// Testbench for the vertical countdown sync block
module vertical_countdown_sync_bench
	import vcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// Driven pins
	logic clk_sys = 1'b0, rst_b = 1'b0, vsync_in = 1'b0;
	logic flyback_in = 1'b0, flyback_peak_in = 1'b0;
	// Observed pins
	logic osc_in, retrace_done_in, h_drive_r, double_line_tick;
	logic vert_reset_r, retrace_active_r, burst_gate_r, h_was, rst_tick;
	logic [VCNT_W-1:0] vcount_r, v;
	// Expected count seen at each reset tick
	logic [VCNT_W-1:0] exp_q[$];
	int fail_count = 0, compares = 0, cycles = 0, last_tick = -1;

	vcs_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .osc_in(osc_in), .vsync_in(vsync_in),
		.retrace_done_in(retrace_done_in), .flyback_in(flyback_in),
		.flyback_peak_in(flyback_peak_in), .h_drive_r(h_drive_r),
		.double_line_tick(double_line_tick), .vert_reset_r(vert_reset_r),
		.retrace_active_r(retrace_active_r), .burst_gate_r(burst_gate_r), .vcount_r(vcount_r));
	vcs_far_side u_far (.clk_sys(clk_sys), .retrace_active_r(retrace_active_r),
		.osc_in(osc_in), .retrace_done_in(retrace_done_in));

	// 100 MHz clock
	initial forever #5 clk_sys = ~clk_sys;

	// Compare and count
	task automatic check(input string what, input logic [VCNT_W-1:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Print counts and verdict
	task automatic close_out;
		$display("counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// Move to just after a later rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	// Pulse vertical sync once the count has reached c
	task automatic sync_at(input logic [VCNT_W-1:0] c);
		while (vcount_r !== c) step(1);
		step(8);
		vsync_in = 1'b1;
		step(10);
		vsync_in = 1'b0;
	endtask : sync_at

	// Hang guard, three frames need about 101k cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 106000) begin
			fail_count++;
			close_out();
		end
	end

	// Watcher: tick spacing, horizontal toggle, resets against the queue
	initial begin
		forever begin
			step(1);
			if (double_line_tick === 1'b1) begin
				if (last_tick >= 0) check("tick spacing", 10'(cycles - last_tick), 10'h040);
				last_tick = cycles;
				h_was = h_drive_r;
				rst_tick = vert_reset_r;
				v = vcount_r;
				step(1);
				check("h drive", h_drive_r, !h_was);
				// Reset tick: count value tells where sync was taken
				if (rst_tick === 1'b1) begin
					check("count at reset", v, exp_q.size() ? exp_q.pop_front() : '1);
					check("count zeroed", vcount_r, VCNT_RST);
					check("retrace start", retrace_active_r, 1'b1);
					step(30);
					check("retrace end", retrace_active_r, 1'b0);
				end
			end
		end
	end

	// Driver: notes each expected reset count, then makes it happen
	initial begin
		void'($urandom(32'h0e1cd983));
		step(4);
		rst_b = 1'b1;
		check("count after reset", vcount_r, VCNT_RST);
		// Burst gate low before the peak, high after it, with random widths
		repeat (3) begin
			flyback_in = 1'b1;
			step(4 + $urandom_range(6));
			check("gate before peak", burst_gate_r, 1'b0);
			flyback_peak_in = 1'b1;
			step(4);
			check("gate after peak", burst_gate_r, 1'b1);
			flyback_in = 1'b0;
			flyback_peak_in = 1'b0;
			step(4);
			check("gate after flyback", burst_gate_r, 1'b0);
		end
		$display("test burst gate done");
		// No sync at all: self reset one count past the default
		exp_q.push_back(DEFAULT_CNT + 10'h001);
		while (exp_q.size() != 0) step(1);
		$display("test default reset done");
		// Sync one count early is ignored, at the window edge it is taken
		exp_q.push_back(WIN_OPEN + 10'h001);
		sync_at(WIN_OPEN - 10'h001);
		sync_at(WIN_OPEN);
		while (exp_q.size() != 0) step(1);
		$display("test window edge done");
		// Sync at a random place inside the window
		v = WIN_OPEN + 10'($urandom_range(15));
		exp_q.push_back(v + 10'h001);
		sync_at(v);
		while (exp_q.size() != 0) step(1);
		step(40);
		$display("test random sync done");
		close_out();
	end
endmodule : vertical_countdown_sync_bench
